// file: hdl/fspc_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fspc_buf_if;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
    logic clear;
    logic [4:0] rd_addr;
    logic [15:0] rd_data;
    modport owner (output wr_en, wr_addr, wr_data, clear, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, clear, rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: hdl/fspc_page_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_page_buffer (
    input wire logic clock,
    input wire logic resetn,
    fspc_buf_if.mem bus
);
    logic [15:0] mem [fspc_pkg::PAGE_WORDS];
    logic [fspc_pkg::PAGE_WORDS-1:0] valid;
    logic [15:0] rd_q;

    // Erased words read as all ones, like blank flash
    genvar i;
    generate
        for (i = 0; i < fspc_pkg::PAGE_WORDS; i++) begin : g_word
            always_ff @(posedge clock) begin
                if (!resetn || bus.clear) begin
                    valid[i] <= 1'b0;
                end else if (bus.wr_en && bus.wr_addr == 5'(i)) begin
                    valid[i] <= 1'b1;
                    mem[i] <= bus.wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rd_q <= 16'hffff;
        end else begin
            rd_q <= valid[bus.rd_addr] ? mem[bus.rd_addr] : 16'hffff;
        end
    end
    assign bus.rd_data = rd_q;
endmodule // fspc_page_buffer
`default_nettype wire

// file: hdl/fspc_pkg.sv
package fspc_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_POINTER = 4'h4;
    localparam logic [3:0] ADDR_DATA = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int BIT_IRQ_ENABLE = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_READ_ENABLE = 4;
    localparam int BIT_LOCK_SET = 3;
    localparam int BIT_PAGE_WRITE = 2;
    localparam int BIT_PAGE_ERASE = 1;
    localparam int BIT_STORE_ENABLE = 0;

    // ------------------------------------------------------------
    // Command patterns in the lower five control bits
    // ------------------------------------------------------------
    localparam logic [4:0] CMD_READ_ENABLE = 5'h11;
    localparam logic [4:0] CMD_LOCK_SET = 5'h09;
    localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
    localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
    localparam logic [4:0] CMD_FILL = 5'h01;

    // ------------------------------------------------------------
    // Flash geometry
    // ------------------------------------------------------------
    localparam int WORD_BITS = 5;
    localparam int PAGE_WORDS = 32;
    localparam int PAGE_BITS = 7;
    localparam int RWW_PAGE_LIMIT = 96;
    localparam logic [15:0] BOOT_RESET_ADDR = 16'h0c00;
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ = 100000000;
    localparam int STORE_WINDOW_CYCLES = 4;
    localparam int LOAD_WINDOW_CYCLES = 3;
    localparam real PROG_TIME_MIN_MS = 3.7;
    localparam real PROG_TIME_MAX_MS = 4.5;
    localparam int PROG_CYCLES = int'($ceil(PROG_TIME_MIN_MS * CLOCK_HZ / 1000.0));

    typedef enum logic [2:0] {
        FSPC_IDLE, FSPC_ERASE, FSPC_WRITE, FSPC_LOCK
    } fspc_state_t;
endpackage

// file: hdl/fspc_top.sv
`timescale 1ns/1ps
`default_nettype none
//Contract
//- Reset vector is 0x0000 when boot fuse is one, else boot address.
//- Software has no path to change any fuse value.
//- Ready interrupt requested while enabled, global flag set, store enable clear.
//- Busy flag set when erase or write targets concurrent region; region blocked.
//- Busy flag cleared when a page load starts.
//- Read enable with store enable plus store re-enables region, clears busy, unless busy.
//- Read enable write during buffer loading aborts load, discards data.
//- Lock-set store programs lock bits from low data, ignores high and pointer.
//- Load within three cycles of lock-set returns lock or fuse bits by pointer bits 1 and 0.
//- Page write store writes buffer to latched page; stalls CPU for stalling region.
//- Page erase store erases latched page; bit clears on completion or timeout.
//- Store enable alone fills buffer word; clears after store or four idle cycles.
//- Store enable stays one until erase or write fully completes.
//- Only the five legal low command patterns take effect.
//- Target address latched when an operation starts.
//- Load reads are bytewise, pointer bit 0 selects the byte.
//- Stalling region erase halts CPU; concurrent region erase leaves stalling region readable.
//- Buffer cleared after page write, read enable write and reset.
//- Data EEPROM write during buffer loading discards buffered data.
//- Erase, write and lock programming take between 3.7 and 4.5 ms.
module fspc_top #(
    parameter int PROG_CYCLES = fspc_pkg::PROG_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic store_instr,
    input wire logic load_instr,
    input wire logic global_irq_flag,
    input wire logic eeprom_write,
    input wire logic boot_vector_select_fuse,
    input wire logic [7:0] fuse_low_bits,
    input wire logic [7:0] fuse_high_bits,
    output logic [15:0] reset_vector,
    output logic selfprog_irq,
    output logic cpu_stall,
    output logic concurrent_region_blocked,
    output logic load_valid,
    output logic [7:0] load_data,
    output logic flash_erase,
    output logic flash_write,
    output logic [6:0] flash_page,
    output logic [4:0] flash_word_addr,
    input wire logic [15:0] flash_word_data,
    input wire logic [15:0] flash_rd_word,
    output logic [15:0] flash_rd_addr,
    output logic [15:0] buf_rd_data
);
    fspc_buf_if bif ();
    fspc_pkg::fspc_state_t state, next_state;

    logic irq_enable, busy, read_enable, lock_set, page_write_cmd, page_erase_cmd, store_enable;
    logic [15:0] pointer;
    logic [15:0] data_word;
    logic [7:0] lock_bits;
    logic [2:0] window;
    logic [31:0] prog_count;
    logic [6:0] latched_page;
    logic loading;
    logic [15:0] fill_word;
    logic ack;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Every access completes in two cycles: one waitrequest high, then low
    wire bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack;
    wire wr_ctrl = avs_write & ack & (avs_address == fspc_pkg::ADDR_CONTROL);
    wire wr_ptr = avs_write & ack & (avs_address == fspc_pkg::ADDR_POINTER);
    wire wr_data = avs_write & ack & (avs_address == fspc_pkg::ADDR_DATA);
    wire [4:0] cmd = avs_writedata[4:0];
    wire prog_active = (state != fspc_pkg::FSPC_IDLE);
    wire window_open = (window != 3'h0);
    wire fill_cmd = store_enable & ~read_enable & ~lock_set & ~page_write_cmd & ~page_erase_cmd;
    wire store_go = store_instr & window_open & ~prog_active;
    wire [6:0] ptr_page = pointer[fspc_pkg::WORD_BITS+fspc_pkg::PAGE_BITS:fspc_pkg::WORD_BITS+1];
    wire page_in_rww = (ptr_page < 7'(fspc_pkg::RWW_PAGE_LIMIT));
    wire prog_done = prog_active && (prog_count == 32'(PROG_CYCLES - 1));
    // Command writes during an operation are ignored except the irq enable bit; store enable has to stay up
    // legal patterns only
    wire cmd_legal = (cmd == fspc_pkg::CMD_READ_ENABLE) | (cmd == fspc_pkg::CMD_LOCK_SET)
        | (cmd == fspc_pkg::CMD_PAGE_WRITE) | (cmd == fspc_pkg::CMD_PAGE_ERASE)
        | (cmd == fspc_pkg::CMD_FILL);
    wire cmd_take = wr_ctrl & cmd_legal & ~prog_active;
    wire lock_read_window = lock_set & store_enable & (window > 3'(fspc_pkg::STORE_WINDOW_CYCLES
        - fspc_pkg::LOAD_WINDOW_CYCLES));
    wire rd_en_abort = cmd_take & (cmd == fspc_pkg::CMD_READ_ENABLE) & loading;
    wire buf_clear = rd_en_abort | (cmd_take & (cmd == fspc_pkg::CMD_READ_ENABLE))
        | (state == fspc_pkg::FSPC_WRITE && prog_done) | (eeprom_write & loading);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_enable <= 1'b0;
            read_enable <= 1'b0;
            lock_set <= 1'b0;
            page_write_cmd <= 1'b0;
            page_erase_cmd <= 1'b0;
            store_enable <= 1'b0;
            window <= 3'h0;
        end else if (cmd_take) begin
            irq_enable <= avs_writedata[fspc_pkg::BIT_IRQ_ENABLE];
            read_enable <= cmd[fspc_pkg::BIT_READ_ENABLE];
            lock_set <= cmd[fspc_pkg::BIT_LOCK_SET];
            page_write_cmd <= cmd[fspc_pkg::BIT_PAGE_WRITE];
            page_erase_cmd <= cmd[fspc_pkg::BIT_PAGE_ERASE];
            store_enable <= 1'b1;
            window <= 3'(fspc_pkg::STORE_WINDOW_CYCLES);
        end else begin
            if (wr_ctrl) begin
                irq_enable <= avs_writedata[fspc_pkg::BIT_IRQ_ENABLE];
            end
            if (window_open) begin
                window <= window - 3'h1;
            end
            if (prog_active) begin
                if (prog_done) begin
                    store_enable <= 1'b0;
                    page_write_cmd <= 1'b0;
                    page_erase_cmd <= 1'b0;
                    lock_set <= 1'b0;
                end
            // auto clear after store or window
            end else if (store_go || (window == 3'h1) || (load_instr && lock_read_window)) begin
                store_enable <= (store_go && (page_write_cmd | page_erase_cmd | lock_set));
                read_enable <= 1'b0;
                lock_set <= store_go & lock_set;
                page_write_cmd <= store_go & page_write_cmd;
                page_erase_cmd <= store_go & page_erase_cmd;
                window <= 3'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pointer, data and programming sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pointer <= 16'h0000;
            data_word <= 16'h0000;
        end else begin
            if (wr_ptr) begin
                pointer <= avs_writedata[15:0];
            end
            if (wr_data) begin
                data_word <= avs_writedata[15:0];
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            fspc_pkg::FSPC_IDLE: begin
                if (store_go && page_erase_cmd) begin
                    next_state = fspc_pkg::FSPC_ERASE;
                end else if (store_go && page_write_cmd) begin
                    next_state = fspc_pkg::FSPC_WRITE;
                end else if (store_go && lock_set) begin
                    next_state = fspc_pkg::FSPC_LOCK;
                end
            end
            fspc_pkg::FSPC_ERASE, fspc_pkg::FSPC_WRITE, fspc_pkg::FSPC_LOCK: begin
                if (prog_done) begin
                    next_state = fspc_pkg::FSPC_IDLE;
                end
            end
            default: next_state = fspc_pkg::FSPC_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= fspc_pkg::FSPC_IDLE;
            prog_count <= 32'h0;
            latched_page <= 7'h00;
            busy <= 1'b0;
            lock_bits <= 8'hff;
            loading <= 1'b0;
        end else begin
            state <= next_state;
            prog_count <= (prog_active && !prog_done) ? prog_count + 32'h1 : 32'h0;
            if (store_go && (page_erase_cmd || page_write_cmd)) begin
                latched_page <= ptr_page;
                if (page_in_rww) begin
                    busy <= 1'b1;
                end
            end else if (store_go && fill_cmd) begin
                busy <= 1'b0;
            end else if (store_go && read_enable) begin
                busy <= 1'b0;
            end
            // lock bits from low data only, programmed bits only fall
            if (store_go && lock_set) begin
                lock_bits[5:2] <= lock_bits[5:2] & data_word[5:2];
            end
            if (buf_clear) begin
                loading <= 1'b0;
            end else if (store_go && fill_cmd) begin
                loading <= 1'b1;
            end
        end
    end

    assign bif.wr_en = store_go & fill_cmd & ~buf_clear;
    assign bif.wr_addr = pointer[fspc_pkg::WORD_BITS:1];
    assign bif.wr_data = data_word;
    assign bif.clear = buf_clear;
    assign bif.rd_addr = flash_word_addr;
    assign buf_rd_data = bif.rd_data;

    fspc_page_buffer u_buf (
        .clock(clock),
        .resetn(resetn),
        .bus(bif)
    );

    // ------------------------------------------------------------
    // Load path and read data
    // ------------------------------------------------------------
    // lock or fuse read; byte select
    wire [7:0] fuse_sel = pointer[0] ? lock_bits : fuse_low_bits;
    wire [7:0] special = pointer[1] ? fuse_high_bits : fuse_sel;
    wire [7:0] flash_byte = pointer[0] ? flash_rd_word[15:8] : flash_rd_word[7:0];
    assign flash_rd_addr = {1'b0, pointer[15:1]};

    always_ff @(posedge clock) begin
        if (!resetn) begin
            load_valid <= 1'b0;
            load_data <= 8'h00;
            avs_readdata <= 32'h0;
            flash_word_addr <= 5'h00;
        end else begin
            load_valid <= load_instr;
            if (load_instr) begin
                load_data <= lock_read_window ? special : flash_byte;
            end
            flash_word_addr <= (state == fspc_pkg::FSPC_WRITE) ? prog_count[4:0] : 5'h00;
            if (bus_req & ~ack) begin
                unique case (avs_address)
                    fspc_pkg::ADDR_CONTROL: avs_readdata <= {24'h0, irq_enable, busy, 1'b0,
                        read_enable, lock_set, page_write_cmd, page_erase_cmd, store_enable};
                    fspc_pkg::ADDR_POINTER: avs_readdata <= {16'h0, pointer};
                    fspc_pkg::ADDR_DATA: avs_readdata <= {16'h0, data_word};
                    fspc_pkg::ADDR_STATUS: avs_readdata <= {24'h0, lock_bits};
                    default: avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs to core and flash array
    // ------------------------------------------------------------
    // reset vector; fuse is input only
    assign reset_vector = boot_vector_select_fuse ? fspc_pkg::APP_RESET_ADDR
        : fspc_pkg::BOOT_RESET_ADDR;
    assign selfprog_irq = irq_enable & global_irq_flag & ~store_enable;
    // stall on stalling region; write stall
    assign cpu_stall = (state == fspc_pkg::FSPC_ERASE || state == fspc_pkg::FSPC_WRITE)
        && (latched_page >= 7'(fspc_pkg::RWW_PAGE_LIMIT));
    assign concurrent_region_blocked = busy;
    assign flash_erase = (state == fspc_pkg::FSPC_ERASE);
    assign flash_write = (state == fspc_pkg::FSPC_WRITE);
    assign flash_page = latched_page;
    wire unused = &{1'b0, flash_word_data, 1'b0};
endmodule // fspc_top
`default_nettype wire

// file: verification/fspc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core issuing one instruction some cycles after a control write
module fspc_cpu_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ctrl_taken,
    input wire logic [1:0] kind,
    input wire logic [2:0] delay,
    output logic store_instr,
    output logic load_instr
);
    logic [2:0] cnt;
    logic armed;
    always_ff @(posedge clock) begin
        store_instr <= 1'b0;
        load_instr <= 1'b0;
        if (!resetn) begin
            armed <= 1'b0;
            cnt <= 3'h0;
        end else if ((ctrl_taken && delay == 3'h0) || (armed && cnt == 3'h1)) begin
            store_instr <= kind == 2'h1;
            load_instr <= kind == 2'h2;
            armed <= 1'b0;
        end else if (ctrl_taken) begin
            armed <= kind != 2'h0;
            cnt <= delay;
        end else if (armed) begin
            cnt <= cnt - 3'h1;
        end
    end
endmodule // fspc_cpu_model
`default_nettype wire

// file: verification/fspc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_top_props #(
    parameter int PROG_CYCLES = 20
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic boot_vector_select_fuse,
    input wire logic global_irq_flag,
    input wire logic load_instr,
    input wire logic [15:0] reset_vector,
    input wire logic selfprog_irq,
    input wire logic cpu_stall,
    input wire logic concurrent_region_blocked,
    input wire logic load_valid,
    input wire logic flash_erase,
    input wire logic flash_write,
    input wire logic [6:0] flash_page
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wire prog_active = flash_erase | flash_write;
    wire req = avs_read | avs_write;
    wire low_page = flash_page < 7'(fspc_pkg::RWW_PAGE_LIMIT);
    logic [31:0] act_cnt;
    // Length of the current flash operation
    always_ff @(posedge clock) begin
        if (!resetn || !prog_active) act_cnt <= 32'h0;
        else act_cnt <= act_cnt + 32'h1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // vector select
    AST_RESET_VECTOR: assert property (reset_vector == (boot_vector_select_fuse ?
        fspc_pkg::APP_RESET_ADDR : fspc_pkg::BOOT_RESET_ADDR)) else $error("reset vector wrong");
    AST_IRQ_GLOBAL: assert property (selfprog_irq |-> global_irq_flag)
        else $error("irq without global flag");
    AST_IRQ_QUIET: assert property (prog_active |-> !selfprog_irq)
        else $error("irq during flash operation");
    AST_BUSY_REGION: assert property (prog_active && low_page |-> concurrent_region_blocked)
        else $error("region not blocked");
    AST_STALL_REGION: assert property (cpu_stall == (prog_active && !low_page))
        else $error("stall wrong");
    AST_LOAD_ANSWER: assert property (load_instr |=> load_valid)
        else $error("load not answered");
    AST_PROG_TIME: assert property ($fell(prog_active) |-> act_cnt == PROG_CYCLES)
        else $error("operation length wrong");
    AST_PAGE_HELD: assert property (prog_active && $past(prog_active) |-> $stable(flash_page))
        else $error("page moved");
    AST_ONE_OP: assert property (!(flash_erase && flash_write))
        else $error("erase and write together");
    AST_WAIT_FIRST: assert property (req && !$past(req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait state wrong");
    AST_WAIT_IDLE: assert property (!req |-> !avs_waitrequest) else $error("wait while idle");
    COV_BUSY: cover property (prog_active && concurrent_region_blocked);
    COV_STALL: cover property (cpu_stall);
    COV_LOAD: cover property (load_valid);
endmodule // fspc_top_props
bind fspc_top fspc_top_props #(.PROG_CYCLES(PROG_CYCLES)) i_props (.clock(clock),
    .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .boot_vector_select_fuse(boot_vector_select_fuse),
    .global_irq_flag(global_irq_flag), .load_instr(load_instr), .reset_vector(reset_vector),
    .selfprog_irq(selfprog_irq), .cpu_stall(cpu_stall), .load_valid(load_valid),
    .concurrent_region_blocked(concurrent_region_blocked), .flash_erase(flash_erase),
    .flash_write(flash_write), .flash_page(flash_page));
`default_nettype wire

// file: verification/fspc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_top_tb;
    localparam int PC = 20;
    typedef struct packed {logic [31:0] e; logic [31:0] m;} fspc_note_t;
    logic clock, resetn, avs_read, avs_write, avs_waitrequest, store_instr, load_instr;
    logic global_irq_flag, eeprom_write, boot_vector_select_fuse, selfprog_irq, cpu_stall;
    logic concurrent_region_blocked, load_valid, flash_erase, flash_write;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0] fl, fh, lk, load_data;
    logic [15:0] reset_vector, buf_rd_data, v;
    logic [6:0] flash_page;
    logic [1:0] kind;
    logic [2:0] delay;
    fspc_note_t q[$], n;
    int error_cnt, tests_run;
    wire ctrl_taken = avs_write && !avs_waitrequest && avs_address == fspc_pkg::ADDR_CONTROL;
    fspc_top #(.PROG_CYCLES(PC)) i_dut (.clock(clock), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .store_instr(store_instr), .load_instr(load_instr),
        .global_irq_flag(global_irq_flag), .eeprom_write(eeprom_write),
        .boot_vector_select_fuse(boot_vector_select_fuse), .fuse_low_bits(fl),
        .fuse_high_bits(fh), .reset_vector(reset_vector), .selfprog_irq(selfprog_irq),
        .cpu_stall(cpu_stall), .concurrent_region_blocked(concurrent_region_blocked),
        .load_valid(load_valid), .load_data(load_data), .flash_erase(flash_erase),
        .flash_write(flash_write), .flash_page(flash_page), .flash_word_addr(),
        .flash_word_data(16'h0000), .flash_rd_word(16'h0000), .flash_rd_addr(),
        .buf_rd_data(buf_rd_data));
    fspc_cpu_model i_cpu (.clock(clock), .resetn(resetn), .ctrl_taken(ctrl_taken),
        .kind(kind), .delay(delay), .store_instr(store_instr), .load_instr(load_instr));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    // Request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            final_report();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        q.push_back('{e, m});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic ctrl(input logic [7:0] c, input logic [1:0] k, input logic [2:0] d);
        kind <= k;
        delay <= d;
        bus(1'b1, fspc_pkg::ADDR_CONTROL, {24'h0, c});
    endtask
    task automatic wait_prog(input logic want);
        int k;
        k = 0;
        while ((flash_erase | flash_write) !== want) begin
            settle(1);
            if (++k > PC * 2 + 40) begin
                error_cnt++;
                final_report();
            end
        end
    endtask
    task automatic fill(input logic [15:0] w);
        bus(1'b1, fspc_pkg::ADDR_DATA, {16'h0, w});
        bus(1'b1, fspc_pkg::ADDR_POINTER, 32'h1);
        ctrl(8'h81, 2'h1, 3'h1);
        settle(5);
    endtask
    task automatic prog(input logic [6:0] pg, input logic [7:0] c);
        logic [31:0] busy;
        busy = (pg < 7'd96) ? 32'h40 : 32'h0;
        bus(1'b1, fspc_pkg::ADDR_POINTER, {19'h0, pg, 6'h0});
        ctrl(c, 2'h1, 3'h3);
        wait_prog(1'b1);
        check(32'(cpu_stall), 32'(pg >= 7'd96));
        check(32'(concurrent_region_blocked), busy >> 6);
        check(32'(selfprog_irq), 32'h0);
        bus(1'b1, fspc_pkg::ADDR_POINTER, 32'h0);
        rd(fspc_pkg::ADDR_CONTROL, {24'h0, c} | busy, 32'hff);
        check(32'(flash_page), 32'(pg));
        wait_prog(1'b0);
        rd(fspc_pkg::ADDR_CONTROL, 32'h80 | busy, 32'hff);
        check(32'(selfprog_irq), 32'h1);
    endtask
    // ------------------------------------------------------------
    // Scoreboard
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (resetn && ((avs_read && !avs_waitrequest) || load_valid)) begin
            n = (q.size() > 0) ? q.pop_front() : '{32'h0, 32'h0};
            if (q.size() == 0 && n.m == 32'h0) check(32'h1, 32'h0);
            else check((load_valid ? {24'h0, load_data} : avs_readdata) & n.m, n.e);
        end
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {avs_address, avs_read, avs_write, avs_writedata, kind, delay} = '0;
        {global_irq_flag, eeprom_write, boot_vector_select_fuse} = '0;
        error_cnt = 0;
        tests_run = 0;
        resetn = 1'b0;
        void'($urandom(32'hf6559bf8));
        fl = 8'($urandom);
        fh = 8'($urandom);
        lk = 8'hff;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        rd(fspc_pkg::ADDR_CONTROL, 32'h0, 32'hff);
        rd(fspc_pkg::ADDR_STATUS, 32'hff, 32'hff);
        for (int i = 0; i < 2; i++) begin
            boot_vector_select_fuse <= i[0];
            settle(1);
            check(32'(reset_vector), i ? 32'h0 : 32'(fspc_pkg::BOOT_RESET_ADDR));
        end
        global_irq_flag <= 1'b1;
        for (int j = 0; j < 32; j++) begin
            if (!(5'(j) inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01})) begin
                ctrl({3'h4, 5'(j)}, 2'h1, 3'h0);
                rd(fspc_pkg::ADDR_CONTROL, 32'h80, 32'hff);
            end
        end
        check(32'(selfprog_irq), 32'h1);
        v = 16'($urandom);
        fill(v);
        check(32'(buf_rd_data), 32'(v));
        ctrl(8'h91, 2'h1, 3'h0);
        settle(4);
        check(32'(buf_rd_data), 32'hffff);
        fill(~v);
        eeprom_write <= 1'b1;
        settle(1);
        eeprom_write <= 1'b0;
        settle(3);
        check(32'(buf_rd_data), 32'hffff);
        prog(7'd10, 8'h83);
        fill(v);
        rd(fspc_pkg::ADDR_CONTROL, 32'h80, 32'hff);
        prog(7'd10, 8'h83);
        ctrl(8'h91, 2'h1, 3'h0);
        rd(fspc_pkg::ADDR_CONTROL, 32'h80, 32'hff);
        prog(7'd100, 8'h83);
        fill(v);
        prog(7'd100, 8'h85);
        settle(3);
        check(32'(buf_rd_data), 32'hffff);
        ctrl(8'h83, 2'h1, 3'h4);
        settle(8);
        check(32'(flash_erase), 32'h0);
        rd(fspc_pkg::ADDR_CONTROL, 32'h80, 32'hff);
        v = 16'($urandom);
        bus(1'b1, fspc_pkg::ADDR_DATA, {16'h0, v});
        ctrl(8'h89, 2'h1, 3'h0);
        settle(PC + 10);
        lk = lk & (v[7:0] | 8'hc3);
        rd(fspc_pkg::ADDR_STATUS, {24'h0, lk}, 32'hff);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, fspc_pkg::ADDR_POINTER, (i == 2) ? 32'h3 : 32'(i == 0));
            q.push_back('{{24'h0, (i == 0) ? lk : (i == 1) ? fl : fh}, 32'hff});
            ctrl(8'h89, 2'h2, 3'(i));
            settle(4);
            rd(fspc_pkg::ADDR_CONTROL, 32'h80, 32'hff);
        end
        final_report();
    end
endmodule // fspc_top_tb
`default_nettype wire
